// >>> design/accel_fifo_pkg.sv
// Shared constants for the accelerometer output data path and sample buffer
package accel_fifo_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int AXIS_BITS = 14;
    localparam int RAW_BITS = 16;
    localparam int NUM_AXES = 3;
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_BITS = 5;
    localparam int CNT_BITS = 6;
    localparam int ENTRY_BITS = AXIS_BITS * NUM_AXES;
    localparam logic [CNT_BITS-1:0] FIFO_FULL_COUNT = 6'h20;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH = 8'h01;
    localparam logic [7:0] ADDR_X_LOW = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
    localparam logic [7:0] ADDR_Y_LOW = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
    localparam logic [7:0] ADDR_Z_LOW = 8'h06;
    localparam logic [7:0] ADDR_BUFFER_SETUP = 8'h09;
    localparam logic [7:0] ADDR_RANGE_CONFIG = 8'h0E;
    localparam logic [7:0] ADDR_CONTROL_MAIN = 8'h2A;
    localparam logic [7:0] ADDR_CONTROL_POWER_SCHEME = 8'h2B;
    localparam logic [7:0] ADDR_OFFSET_BASE = 8'h2F;
    localparam int NUM_OFFSET_REGS = 6;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_FAST_READ_BIT = 1;
    localparam int CTRL_LOW_NOISE_BIT = 2;
    localparam int SETUP_MODE_LSB = 6;
    localparam int SETUP_WM_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] BUFFER_SETUP_RST = 8'h00;
    localparam logic [7:0] CONTROL_MAIN_RST = 8'h00;
    localparam logic [7:0] POWER_SCHEME_RST = 8'h00;
    localparam logic [7:0] RANGE_CONFIG_RST = 8'h00;
    localparam logic [7:0] OFFSET_RST = 8'h00;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        BUF_DISABLED = 2'h0,
        BUF_CIRCULAR = 2'h1,
        BUF_FILL = 2'h2,
        BUF_TRIGGER = 2'h3
    } buffer_mode_t;

    localparam logic [1:0] RANGE_2G = 2'h0;
    localparam logic [1:0] RANGE_4G = 2'h1;
    localparam logic [1:0] SCHEME_HIGH_RES = 2'h2;
    localparam logic [1:0] SCHEME_LOW_POWER = 2'h3;

    typedef enum logic [2:0] {
        ST_TRIM = 3'h1,
        ST_STANDBY = 3'h2,
        ST_ACTIVE = 3'h4
    } dev_state_t;

endpackage

// >>> design/accel_sample_fifo_output.sv
// Accelerometer output registers, range scaling, offset trim and 32-sample buffer
// What this block does
// - Each axis is a signed 14-bit value split into high and low byte registers.
// - High byte holds upper eight bits; fast read walks only the three high bytes.
// - Fast read cleared gives full resolution, high and low bytes both read.
// - Two-g range encodes -2g to +1.99975g at 4096 counts per g.
// - Eight-g range encodes -8g to +7.999g at 1024 counts per g.
// - Eight-bit results are sixty-four times coarser than fourteen-bit ones.
// - Up to thirty-two samples of all three axes are buffered.
// - The buffer works at every output sample rate.
// - Buffered samples read at fourteen-bit width or eight-bit upper part.
// - Buffer setup selects fill, circular, trigger or disabled mode.
// - Fill mode keeps first 32, flags overflow, stores nothing more while full.
// - Circular mode overwrites the oldest entry, keeping the latest 32.
// - Trigger mode wraps on pre-trigger samples, then fills only free entries, up to a set number after it.
// - A watermark flag rises when count reaches a level from 1 to 32.
// - Low-noise select limits the dynamic range to four g.
// - Power scheme 10 selects high-resolution oversampling.
// - Power scheme 11 selects reduced oversampling for lowest current.
// - Factory trim loads at power-up before any measurement is taken.
// - Six user registers add a zero-g offset per axis over factory trim.
// - Registers survive active to standby; buffer restarts on standby to active.
`timescale 1ns/100ps
`default_nettype none
module accel_sample_fifo_output (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic reg_start_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic sample_valid_in,
    input wire logic [accel_fifo_pkg::RAW_BITS-1:0] sample_x_in,
    input wire logic [accel_fifo_pkg::RAW_BITS-1:0] sample_y_in,
    input wire logic [accel_fifo_pkg::RAW_BITS-1:0] sample_z_in,
    input wire logic trigger_in,
    output logic trim_req_out,
    input wire logic trim_ack_in,
    input wire logic [accel_fifo_pkg::AXIS_BITS-1:0] trim_x_in,
    input wire logic [accel_fifo_pkg::AXIS_BITS-1:0] trim_y_in,
    input wire logic [accel_fifo_pkg::AXIS_BITS-1:0] trim_z_in,
    output logic active_out,
    output logic low_noise_out,
    output logic [1:0] power_scheme_out,
    output logic watermark_out,
    output logic overflow_out
);
    import accel_fifo_pkg::*;

    // ****************************************
    // Helper functions
    // ****************************************
    // Saturate a wide signed sum into the 14-bit output code
    function automatic logic [AXIS_BITS-1:0] sat14(input logic signed [17:0] v);
        if (v > 18'sd8191) begin
            sat14 = 14'h1FFF;
        end else if (v < -18'sd8192) begin
            sat14 = 14'h2000;
        end else begin
            sat14 = v[AXIS_BITS-1:0];
        end
    endfunction

    // Scale raw 1/4096 g data to the range, then add factory and user offsets
    function automatic logic [AXIS_BITS-1:0] scale_axis(input logic [RAW_BITS-1:0] raw,
            input logic [1:0] shift, input logic [AXIS_BITS-1:0] trim, input logic [AXIS_BITS-1:0] user);
        logic signed [17:0] sum;
        sum = 18'(signed'(raw) >>> shift) + 18'(signed'(trim)) + 18'(signed'(user));
        scale_axis = sat14(sum);
    endfunction

    // Read value of the register at a given offset
    function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] status,
            input logic [ENTRY_BITS-1:0] s, input logic [7:0] setup, input logic [7:0] ctrl,
            input logic [7:0] scheme, input logic [7:0] range_cfg);
        if (a == ADDR_STATUS) begin
            read_mux = status;
        end else if (a == ADDR_X_HIGH) begin
            // six bits dropped, 64 times coarser
            read_mux = s[41:34];
        end else if (a == ADDR_X_LOW) begin
            read_mux = {s[33:28], 2'h0};
        end else if (a == ADDR_Y_HIGH) begin
            read_mux = s[27:20];
        end else if (a == ADDR_Y_LOW) begin
            read_mux = {s[19:14], 2'h0};
        end else if (a == ADDR_Z_HIGH) begin
            read_mux = s[13:6];
        end else if (a == ADDR_Z_LOW) begin
            read_mux = {s[5:0], 2'h0};
        end else if (a == ADDR_BUFFER_SETUP) begin
            read_mux = setup;
        end else if (a == ADDR_RANGE_CONFIG) begin
            read_mux = range_cfg;
        end else if (a == ADDR_CONTROL_MAIN) begin
            read_mux = ctrl;
        end else if (a == ADDR_CONTROL_POWER_SCHEME) begin
            read_mux = scheme;
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    // ****************************************
    // State and configuration
    // ****************************************
    dev_state_t state, next_state;
    logic [7:0] buffer_setup, control_main, control_power_scheme, range_config;
    logic [7:0] user_offset [0:NUM_OFFSET_REGS-1];
    logic [7:0] reg_ptr;
    logic [NUM_AXES-1:0][AXIS_BITS-1:0] trim_value, latest;
    logic [PTR_BITS-1:0] wr_ptr, rd_ptr;
    logic [CNT_BITS-1:0] fifo_count, post_count;
    logic overflow, trigger_seen;
    logic [ENTRY_BITS-1:0] mem_rdata;

    wire fast_read = control_main[CTRL_FAST_READ_BIT];
    wire low_noise = control_main[CTRL_LOW_NOISE_BIT];
    wire buffer_mode_t mode = buffer_mode_t'(buffer_setup[SETUP_MODE_LSB+:2]);
    wire [CNT_BITS-1:0] wm_raw = buffer_setup[SETUP_WM_LSB+:CNT_BITS];
    // Levels above 32 are clamped so the watermark stays in 1 to 32
    wire [CNT_BITS-1:0] wm_level = (wm_raw > FIFO_FULL_COUNT) ? FIFO_FULL_COUNT : wm_raw;
    wire fifo_on = (mode != BUF_DISABLED);
    wire fifo_full = (fifo_count == FIFO_FULL_COUNT);
    wire fifo_empty = (fifo_count == 6'h00);

    // low noise caps range at four g
    wire [1:0] range_sel = (low_noise && range_config[1:0] > RANGE_4G) ? RANGE_4G : range_config[1:0];
    // two-g keeps 4096 counts per g, eight-g shifts by two to 1024 counts per g
    wire [1:0] range_shift = (range_sel == RANGE_2G) ? 2'h0 : (range_sel == RANGE_4G) ? 2'h1 : 2'h2;

    // ****************************************
    // Device state machine
    // ****************************************
    // Trim first, then follow the active bit between standby and active
    always_comb begin
        next_state = state;
        case (state)
            ST_TRIM: begin
                if (trim_ack_in) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (control_main[CTRL_ACTIVE_BIT]) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!control_main[CTRL_ACTIVE_BIT]) begin
                    next_state = ST_STANDBY;
                end
            end
            default: next_state = ST_TRIM;
        endcase
    end

    // trim captured once before measurement can start
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= ST_TRIM;
            trim_req_out <= 1'b1;
            trim_value <= '0;
            active_out <= 1'b0;
        end else begin
            state <= next_state;
            active_out <= (next_state == ST_ACTIVE);
            if (state == ST_TRIM && trim_ack_in) begin
                trim_req_out <= 1'b0;
                trim_value <= {trim_x_in, trim_y_in, trim_z_in};
            end
        end
    end

    // ****************************************
    // Sample path
    // ****************************************
    // no rate gating, every sample strobe in active state is taken
    wire take_sample = sample_valid_in && (state == ST_ACTIVE);
    wire go_active = (state == ST_STANDBY) && (next_state == ST_ACTIVE);
    wire [RAW_BITS-1:0] raw_axis [0:NUM_AXES-1];
    wire [NUM_AXES-1:0][AXIS_BITS-1:0] scaled;
    assign raw_axis[0] = sample_x_in;
    assign raw_axis[1] = sample_y_in;
    assign raw_axis[2] = sample_z_in;

    // offset from high/low user registers, each axis kept as 14-bit code
    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            wire [AXIS_BITS-1:0] user_off = {user_offset[2*g], user_offset[2*g+1][7:2]};
            assign scaled[NUM_AXES-1-g] = scale_axis(raw_axis[g], range_shift, trim_value[NUM_AXES-1-g], user_off);
        end
    endgenerate

    // Latest sample is what the data registers show when the buffer is off
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            latest <= '0;
        end else if (take_sample) begin
            latest <= scaled;
        end
    end

    // ****************************************
    // Register access with auto-increment pointer
    // ****************************************
    wire last_of_sample = fast_read ? (reg_ptr == ADDR_Z_HIGH) : (reg_ptr == ADDR_Z_LOW);
    // fast read hops high to high, otherwise every byte in turn
    wire [7:0] next_ptr = last_of_sample ? ADDR_STATUS :
                          (fast_read && (reg_ptr == ADDR_X_HIGH || reg_ptr == ADDR_Y_HIGH)) ? reg_ptr + 8'h02 :
                          reg_ptr + 8'h01;
    // pop after last byte of either width; an address phase never pops
    wire pop = reg_rd_in && !reg_start_in && fifo_on && !fifo_empty && last_of_sample;
    wire [ENTRY_BITS-1:0] shown = fifo_on ? mem_rdata : latest;
    wire [7:0] status_byte = {overflow, watermark_out, fifo_count};
    wire [7:0] read_value = read_mux(reg_ptr, status_byte, shown, buffer_setup, control_main,
                                     control_power_scheme, range_config);

    // Pointer and read data; the pointer walks the way a bus burst would
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_ptr <= ADDR_STATUS;
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= read_value;
            end
            if (reg_start_in) begin
                reg_ptr <= reg_addr_in;
            end else if (reg_rd_in || reg_wr_in) begin
                reg_ptr <= next_ptr;
            end
        end
    end

    // buffer setup register, power scheme field, nothing here clears on standby
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            buffer_setup <= BUFFER_SETUP_RST;
            control_main <= CONTROL_MAIN_RST;
            control_power_scheme <= POWER_SCHEME_RST;
            range_config <= RANGE_CONFIG_RST;
            for (int i = 0; i < NUM_OFFSET_REGS; i++) begin
                user_offset[i] <= OFFSET_RST;
            end
        end else if (reg_wr_in && !reg_start_in) begin
            if (reg_ptr == ADDR_BUFFER_SETUP) begin
                buffer_setup <= reg_wdata_in;
            end else if (reg_ptr == ADDR_CONTROL_MAIN) begin
                control_main <= reg_wdata_in;
            end else if (reg_ptr == ADDR_CONTROL_POWER_SCHEME) begin
                control_power_scheme <= {6'h00, reg_wdata_in[1:0]};
            end else if (reg_ptr == ADDR_RANGE_CONFIG) begin
                range_config <= {6'h00, reg_wdata_in[1:0]};
            end
            for (int i = 0; i < NUM_OFFSET_REGS; i++) begin
                if (reg_ptr == ADDR_OFFSET_BASE + 8'(i)) begin
                    user_offset[i] <= reg_wdata_in;
                end
            end
        end
    end

    // Analog front end follows the control fields directly
    assign low_noise_out = control_main[CTRL_LOW_NOISE_BIT];
    assign power_scheme_out = control_power_scheme[1:0];

    // ****************************************
    // Sample buffer
    // ****************************************
    // after the trigger, freeze once the post count reaches the watermark level
    wire frozen = (mode == BUF_TRIGGER) && trigger_seen && (post_count >= wm_level);
    wire wraps = (mode == BUF_CIRCULAR) || (mode == BUF_TRIGGER && !trigger_seen);
    // fill mode refuses when full, storing resumes once a pop frees room
    wire push = take_sample && fifo_on && !frozen && (!fifo_full || pop || wraps);
    // circular overwrite drops the oldest entry
    wire drop = push && fifo_full && !pop;
    wire lost = take_sample && fifo_on && !push;
    wire [PTR_BITS-1:0] next_rd_ptr = (pop || drop) ? rd_ptr + 5'h01 : rd_ptr;

    // thirty-two entries of all three axes
    sample_store u_store (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr),
        .wr_data_in(scaled),
        .rd_addr_in(next_rd_ptr),
        .rd_data_out(mem_rdata)
    );

    // Pointers and count; a standby to active step restarts the buffer
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || go_active) begin
            wr_ptr <= 5'h00;
            rd_ptr <= 5'h00;
            fifo_count <= 6'h00;
            trigger_seen <= 1'b0;
            post_count <= 6'h00;
        end else begin
            rd_ptr <= next_rd_ptr;
            if (push) begin
                wr_ptr <= wr_ptr + 5'h01;
            end
            if (push && !pop && !drop) begin
                fifo_count <= fifo_count + 6'h01;
            end else if (pop && !push) begin
                fifo_count <= fifo_count - 6'h01;
            end
            if (mode == BUF_TRIGGER && trigger_in && state == ST_ACTIVE) begin
                trigger_seen <= 1'b1;
            end
            if (trigger_seen && push) begin
                post_count <= post_count + 6'h01;
            end
        end
    end

    // Overflow is sticky until status is read; a new loss in that cycle wins over the clear
    wire status_read = reg_rd_in && !reg_start_in && (reg_ptr == ADDR_STATUS);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || go_active) begin
            overflow <= 1'b0;
        end else if (lost) begin
            overflow <= 1'b1;
        end else if (status_read) begin
            overflow <= 1'b0;
        end
    end

    // watermark level 1 to 32, zero switches the flag off
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            watermark_out <= 1'b0;
        end else begin
            watermark_out <= fifo_on && (wm_level != 6'h00) && (fifo_count >= wm_level);
        end
    end
    assign overflow_out = overflow;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_fill_holds;
        (mode == BUF_FILL) && fifo_full && take_sample && !pop && !reg_wr_in |=> fifo_full && overflow_out;
    endproperty
    a_fill_holds: assert property (p_fill_holds) else $error("fill mode stored past full");

    property p_circular_keeps;
        (mode == BUF_CIRCULAR) && fifo_full && take_sample && !reg_wr_in && !go_active |=> fifo_full;
    endproperty
    a_circular_keeps: assert property (p_circular_keeps) else $error("circular mode lost depth");

    property p_depth;
        fifo_count <= FIFO_FULL_COUNT;
    endproperty
    a_depth: assert property (p_depth) else $error("buffer count above 32");

    property p_watermark;
        fifo_on && (wm_level != 6'h00) && (fifo_count >= wm_level) |=> watermark_out;
    endproperty
    a_watermark: assert property (p_watermark) else $error("watermark flag missing");

    property p_fast_skip;
        reg_rd_in && !reg_start_in && fast_read && (reg_ptr == ADDR_X_HIGH) |=> reg_ptr == ADDR_Y_HIGH;
    endproperty
    a_fast_skip: assert property (p_fast_skip) else $error("fast read did not skip low byte");

    property p_full_walk;
        reg_rd_in && !reg_start_in && !fast_read && (reg_ptr == ADDR_X_HIGH) |=> reg_ptr == ADDR_X_LOW;
    endproperty
    a_full_walk: assert property (p_full_walk) else $error("full read skipped low byte");

    property p_trim_first;
        (state == ST_TRIM) |-> !push && trim_req_out;
    endproperty
    a_trim_first: assert property (p_trim_first) else $error("sample stored before trim load");

    property p_restart;
        go_active |=> (fifo_count == 6'h00) && !overflow_out;
    endproperty
    a_restart: assert property (p_restart) else $error("buffer not restarted on activation");

    property p_low_noise_range;
        low_noise && (range_config[1:0] > RANGE_4G) |-> range_shift == 2'h1;
    endproperty
    a_low_noise_range: assert property (p_low_noise_range) else $error("low noise range not capped");

    property p_low_byte;
        reg_rd_in && !reg_start_in && (reg_ptr == ADDR_Z_LOW) |=> reg_rdata_out[1:0] == 2'h0 && reg_rvalid_out;
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte padding wrong");

    c_overflow: cover property (lost ##1 overflow_out);
    c_circular_wrap: cover property ((mode == BUF_CIRCULAR) && drop);
    c_trigger_freeze: cover property ((mode == BUF_TRIGGER) && trigger_seen ##[1:64] frozen);
    c_fast_burst: cover property (fast_read && pop);
endmodule
`default_nettype wire

// >>> design/sample_store.sv
// Sample memory for the buffer: one write port, registered read with write bypass
`timescale 1ns/100ps
`default_nettype none
module sample_store (
    input wire logic clk_sys_in,
    input wire logic wr_en_in,
    input wire logic [accel_fifo_pkg::PTR_BITS-1:0] wr_addr_in,
    input wire logic [accel_fifo_pkg::ENTRY_BITS-1:0] wr_data_in,
    input wire logic [accel_fifo_pkg::PTR_BITS-1:0] rd_addr_in,
    output logic [accel_fifo_pkg::ENTRY_BITS-1:0] rd_data_out
);
    import accel_fifo_pkg::*;

    logic [ENTRY_BITS-1:0] mem [0:FIFO_DEPTH-1];
    wire bypass = wr_en_in && (wr_addr_in == rd_addr_in);

    // Write and registered read; bypass keeps an entry written into an empty buffer visible
    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= bypass ? wr_data_in : mem[rd_addr_in];
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the output registers and sample buffer
`timescale 1ns/100ps
`default_nettype none
module tb;
    import accel_fifo_pkg::*;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, st = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b0, trg = 1'b0;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
    logic rvalid, ack, act, lno, wm, ovf, treq;
    logic [1:0] pws;
    logic [15:0] sx = 16'h0000, sy = 16'hFFFF, sz = 16'h0123;
    logic [13:0] tx, ty, tz;
    int errors = 0, checks = 0, cyc = 0;
    // Clock and hang guard
    initial forever #20 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            end_sim;
        end
    end
    accel_sample_fifo_output dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_start_in(st),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .reg_rvalid_out(rvalid), .sample_valid_in(sv), .sample_x_in(sx), .sample_y_in(sy),
        .sample_z_in(sz), .trigger_in(trg), .trim_req_out(treq), .trim_ack_in(ack), .trim_x_in(tx),
        .trim_y_in(ty), .trim_z_in(tz), .active_out(act), .low_noise_out(lno),
        .power_scheme_out(pws), .watermark_out(wm), .overflow_out(ovf));
    trim_store_model trim (.clk_sys_in(clk_sys_in), .trim_req_in(treq), .trim_ack_out(ack),
        .trim_x_out(tx), .trim_y_out(ty), .trim_z_out(tz));
    // Inputs move 1 ns after the edge so the design samples settled values
    task automatic tick;
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic cmp(string n, logic [8:0] got, logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic go(logic [7:0] a);
        st = 1'b1;
        addr = a;
        tick;
        st = 1'b0;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        go(a);
        wr = 1'b1;
        wdat = d;
        tick;
        wr = 1'b0;
    endtask
    // Read is held high for the whole burst, one byte checked per cycle
    task automatic rd_burst(logic [7:0] a, logic [7:0] e[$]);
        go(a);
        rd = 1'b1;
        foreach (e[i]) begin
            tick;
            cmp("read", {rvalid, rdat}, {1'b1, e[i]});
        end
        rd = 1'b0;
    endtask
    task automatic push_n(int n, logic [15:0] base);
        // Active state starts one edge after the control write, so wait before the first strobe
        tick;
        sv = 1'b1;
        for (int i = 0; i < n; i++) begin
            sx = base + 16'(i);
            tick;
        end
        sv = 1'b0;
        tick;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) tick;
        rst_n_in = 1'b1;
        cmp("trim_req", {8'h00, treq}, 9'h001);
        rd_burst(ADDR_CONTROL_MAIN, '{8'h00, 8'h00});
        rd_burst(ADDR_BUFFER_SETUP, '{8'h00});
        rd_burst(8'h7F, '{8'h00});
        wr_reg(ADDR_CONTROL_POWER_SCHEME, 8'h02);
        cmp("scheme", {7'h00, pws}, 9'h002);
        wr_reg(ADDR_CONTROL_POWER_SCHEME, 8'h03);
        cmp("scheme", {7'h00, pws}, 9'h003);
        wr_reg(ADDR_CONTROL_MAIN, 8'h04);
        cmp("low_noise", {8'h00, lno}, 9'h001);
        cmp("trim_req", {8'h00, treq}, 9'h000);
        wr_reg(ADDR_BUFFER_SETUP, 8'h84);
        wr_reg(ADDR_CONTROL_MAIN, 8'h01);
        push_n(33, 16'h0000);
        cmp("overflow", {8'h00, ovf}, 9'h001);
        cmp("watermark", {8'h00, wm}, 9'h001);
        cmp("active", {8'h00, act}, 9'h001);
        rd_burst(ADDR_STATUS, '{8'hE0, 8'h00, 8'h10, 8'hFF, 8'hFC, 8'h04, 8'h8C, 8'h5F});
        push_n(1, 16'h0000);
        rd_burst(ADDR_STATUS, '{8'h60});
        wr_reg(ADDR_CONTROL_MAIN, 8'h03);
        rd_burst(ADDR_X_HIGH, '{8'h00, 8'hFF, 8'h04, 8'h5F});
        wr_reg(ADDR_CONTROL_MAIN, 8'h00);
        wr_reg(ADDR_BUFFER_SETUP, 8'h44);
        cmp("active", {8'h00, act}, 9'h000);
        wr_reg(ADDR_CONTROL_MAIN, 8'h01);
        push_n(34, 16'h0000);
        rd_burst(ADDR_STATUS, '{8'h60, 8'h00, 8'h18});
        wr_reg(ADDR_CONTROL_MAIN, 8'h00);
        wr_reg(ADDR_BUFFER_SETUP, 8'h00);
        wr_reg(ADDR_RANGE_CONFIG, 8'h02);
        wr_reg(8'h30, 8'h04);
        wr_reg(ADDR_CONTROL_MAIN, 8'h01);
        sy = 16'hFFF0;
        push_n(1, 16'h0400);
        rd_burst(ADDR_X_HIGH, '{8'h04, 8'h14, 8'hFF, 8'hF0, 8'h01, 8'h20});
        wr_reg(ADDR_CONTROL_MAIN, 8'h05);
        push_n(1, 16'h0400);
        rd_burst(ADDR_X_HIGH, '{8'h08, 8'h14, 8'hFF, 8'hE0, 8'h02, 8'h44});
        // Trigger mode: three before the event, two after it, then two refused
        wr_reg(ADDR_CONTROL_MAIN, 8'h00);
        wr_reg(ADDR_BUFFER_SETUP, 8'hC2);
        wr_reg(ADDR_CONTROL_MAIN, 8'h01);
        push_n(3, 16'h0000);
        trg = 1'b1;
        tick;
        trg = 1'b0;
        push_n(4, 16'h0000);
        rd_burst(ADDR_STATUS, '{8'hC5});
        end_sim;
    end
endmodule
`default_nettype wire

// >>> testbench/trim_store_model.sv
// Factory trim store model that answers the trim request
`timescale 1ns/100ps
`default_nettype none
module trim_store_model (
    input wire logic clk_sys_in,
    input wire logic trim_req_in,
    output logic trim_ack_out,
    output logic [13:0] trim_x_out,
    output logic [13:0] trim_y_out,
    output logic [13:0] trim_z_out
);
    int wait_cnt = 0;
    logic ack = 1'b0;
    always @(posedge clk_sys_in) begin
        ack <= trim_req_in && wait_cnt == 8;
        wait_cnt <= trim_req_in ? wait_cnt + 1 : 0;
    end
    // Data lines toggle outside the ack so a stale value is never taken
    assign trim_ack_out = ack;
    assign trim_x_out = ack ? 14'h0004 : {14{wait_cnt[0]}};
    assign trim_y_out = ack ? 14'h0000 : {14{wait_cnt[0]}};
    assign trim_z_out = ack ? 14'h0000 : {14{wait_cnt[0]}};
endmodule
`default_nettype wire
